// ---- bwi_consts.svh ----
`ifndef BWI_CONSTS_SVH
`define BWI_CONSTS_SVH

// bus timing counter width and carry value
`define BWI_TMR_W 10
`define BWI_TMR_MAX 10'h3ff
// low three bits all ones marks one minimum span elapsed
`define BWI_MIN_MASK 3'h7

// preload values chosen by the two select bits
`define BWI_PRE_0 10'h000
`define BWI_PRE_1 10'h001
`define BWI_PRE_2 10'h002
`define BWI_PRE_3 10'h003

// field positions inside the second interrupt enable register
`define BWI_IEN_BUS_BIT 0
`define BWI_IEN_TMO_BIT 7

// field positions inside the two priority registers
`define BWI_PRI_BUS_BIT 0
`define BWI_PRI_TMO_BIT 7

// reset values
`define BWI_RECEIVED_BIT_RST 1'b1
`define BWI_PIN_RST 1'b1

`endif

// ---- bwi_pkg.sv ----
`default_nettype none
package bwi_pkg;

  // master sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, // not master
    ST_START = 3'b001, // sda low, scl high
    ST_LOW = 3'b010, // scl driven low
    ST_HIGH = 3'b011, // scl released
    ST_STOP1 = 3'b100, // sda low, scl released
    ST_STOP2 = 3'b101, // sda released, wait
    ST_RSTART = 3'b110 // sda high, scl released
  } bwi_state_t;

  // one-cycle software write strobes to the control register
  typedef struct packed {
    logic clr_xmit; // clear transmit active
    logic go_idle; // ignore bus until next start
    logic clear_bit_ready; // clear bit ready flag
    logic clr_arb; // clear arbitration lost
    logic clr_start; // clear start seen
    logic clr_stop; // clear stop seen
    logic gen_start; // request (repeated) start
    logic gen_stop; // request stop
  } bwi_cmd_t;

  // sticky status flags
  typedef struct packed {
    logic bit_ready_flag;
    logic arbitration_lost_flag;
    logic start_seen_flag;
    logic stop_seen_flag;
  } bwi_flags_t;

endpackage : bwi_pkg
`default_nettype wire

// ---- bwi_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bwi_consts.svh"

module bwi_top (
  input wire logic mclk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic bus_enable, // interface enabled
  input wire logic timeout_run_bit, // timer run bit of bus_config_reg
  input wire logic timing_preload_sel0, // preload select low bit
  input wire logic timing_preload_sel1, // preload select high bit
  input wire bwi_pkg::bwi_cmd_t sw_cmd, // control register write strobes
  input wire logic bit_reg_wr, // bus_bit_reg write strobe
  input wire logic bit_reg_wdata, // bit to transmit
  input wire logic bit_reg_rd, // bus_bit_reg read strobe
  input wire logic global_irq_enable, // global enable
  input wire logic [7:0] interrupt_enable_reg_b, // second enable register
  input wire logic [7:0] priority_reg_high, // high priority register
  input wire logic [7:0] priority_reg_low, // low priority register
  input wire logic scl_i, // scl pin level
  output logic scl_o, // scl drive value
  output logic scl_oe, // scl driven
  input wire logic sda_i, // sda pin level
  output logic sda_o, // sda drive value
  output logic sda_oe, // sda driven
  output logic [7:0] bus_control_reg, // control register read value
  output logic [7:0] bus_bit_reg, // bit register read value
  output logic bus_irq, // bus interrupt request
  output logic timeout_irq, // timeout interrupt pulse
  output logic [1:0] bus_priority, // bus interrupt priority
  output logic [1:0] timeout_priority // timeout interrupt priority
);

  // preload select decode
  function automatic logic [`BWI_TMR_W-1:0] pre_val(input logic s1, input logic s0);
    case ({s1, s0})
      2'b00: pre_val = `BWI_PRE_0;
      2'b01: pre_val = `BWI_PRE_1;
      2'b10: pre_val = `BWI_PRE_2;
      default: pre_val = `BWI_PRE_3;
    endcase
  endfunction : pre_val

  // pin synchronisers, three stages each
  logic [2:0] scl_sy_q, scl_sy_d; // scl chain
  logic [2:0] sda_sy_q, sda_sy_d; // sda chain
  logic scl_st_q, scl_st_d; // accepted scl level
  logic sda_st_q, sda_st_d; // accepted sda level
  logic scl_rise, scl_fall, sda_rise, sda_fall; // accepted changes

  // shift in, accept a change once stages two and three agree
  always_comb begin
    scl_sy_d = {scl_sy_q[1:0], scl_i};
    sda_sy_d = {sda_sy_q[1:0], sda_i};
    scl_st_d = (scl_sy_q[1] == scl_sy_q[2]) ? scl_sy_q[2] : scl_st_q;
    sda_st_d = (sda_sy_q[1] == sda_sy_q[2]) ? sda_sy_q[2] : sda_st_q;
    scl_rise = scl_st_d & ~scl_st_q;
    scl_fall = ~scl_st_d & scl_st_q;
    sda_rise = sda_st_d & ~sda_st_q;
    sda_fall = ~sda_st_d & sda_st_q;
  end

  // synchroniser registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      scl_st_q <= 1'b1;
      sda_st_q <= 1'b1;
    end else begin
      scl_sy_q <= scl_sy_d;
      sda_sy_q <= sda_sy_d;
      scl_st_q <= scl_st_d;
      sda_st_q <= sda_st_d;
    end
  end

  // interface state
  bwi_pkg::bwi_state_t st_q, st_d; // master sequencer
  bwi_pkg::bwi_flags_t flg_q, flg_d; // sticky flags
  logic in_frame_q, in_frame_d; // between start and stop
  logic idle_q, idle_d; // idle slave, bus ignored
  logic xmit_q, xmit_d; // transmit active
  logic xbit_q, xbit_d; // bit to transmit
  logic received_bit_q, received_bit_d; // received bit
  logic [`BWI_TMR_W-1:0] tmr_q, tmr_d; // bus timing counter
  logic min_q, min_d; // minimum span elapsed
  logic tmr_run, carry, attention_flag, hold, mstr; // helpers
  logic scl_edge, st_chg; // counter restart causes

  // bus timing counter
  always_comb begin
    mstr = (st_q != bwi_pkg::ST_IDLE);
    tmr_run = bus_enable & timeout_run_bit & (in_frame_q | mstr);
    carry = tmr_run & in_frame_q & (tmr_q == `BWI_TMR_MAX);
    scl_edge = bus_enable & (scl_rise | scl_fall);
    st_chg = (st_d != st_q);
    tmr_d = tmr_q;
    min_d = min_q;
    if (scl_edge || st_chg || carry) begin
      // restart spans from every scl change and sequencer step
      tmr_d = pre_val(timing_preload_sel1, timing_preload_sel0);
      min_d = 1'b0;
    end else if (tmr_run) begin
      tmr_d = tmr_q + 10'h001;
      if (tmr_q[2:0] == `BWI_MIN_MASK) begin
        min_d = 1'b1;
      end
    end
  end

  // counter registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tmr_q <= '0;
      min_q <= 1'b0;
    end else begin
      tmr_q <= tmr_d;
      min_q <= min_d;
    end
  end

  // flags, frame tracking and master sequencer
  always_comb begin
    flg_d = flg_q;
    in_frame_d = in_frame_q;
    idle_d = idle_q;
    xmit_d = xmit_q;
    xbit_d = xbit_q;
    received_bit_d = received_bit_q;
    st_d = st_q;
    attention_flag = |flg_q;
    // ready or any other flag keeps the low period stretched
    hold = attention_flag | ~min_q;
    // software clears first, hardware sets below win
    if (sw_cmd.clear_bit_ready || bit_reg_wr || bit_reg_rd) begin
      flg_d.bit_ready_flag = 1'b0;
    end
    if (sw_cmd.clr_arb) begin
      flg_d.arbitration_lost_flag = 1'b0;
    end
    if (sw_cmd.clr_start) begin
      flg_d.start_seen_flag = 1'b0;
    end
    if (sw_cmd.clr_stop) begin
      flg_d.stop_seen_flag = 1'b0;
    end
    if (sw_cmd.clr_xmit) begin
      xmit_d = 1'b0;
    end
    if (sw_cmd.go_idle && !mstr) begin
      idle_d = 1'b1;
    end
    if (bit_reg_wr) begin
      xbit_d = bit_reg_wdata;
      xmit_d = 1'b1;
    end
    if (bus_enable) begin
      // receive on every rising scl
      if (scl_rise) begin
        received_bit_d = sda_st_q;
        if (!idle_q || mstr) begin
          flg_d.bit_ready_flag = 1'b1;
        end
        // released a one but the line is low
        if (xmit_q && xbit_q && !sda_st_q) begin
          flg_d.arbitration_lost_flag = 1'b1;
          xmit_d = 1'b0;
          st_d = bwi_pkg::ST_IDLE;
        end
      end
      // start: sda falls while scl high
      if (sda_fall && scl_st_q) begin
        in_frame_d = 1'b1;
        if (!idle_q || mstr) begin
          flg_d.start_seen_flag = 1'b1;
        end
        idle_d = 1'b0;
      end
      // stop: sda rises while scl high
      if (sda_rise && scl_st_q) begin
        in_frame_d = 1'b0;
        if (!idle_q || mstr) begin
          flg_d.stop_seen_flag = 1'b1;
        end
      end
      // master sequencer, timed steps wait a minimum span; gen_start in ST_IDLE and gen_stop or gen_start in ST_LOW act at once
      case (st_q)
        bwi_pkg::ST_IDLE: begin
          if (sw_cmd.gen_start && !in_frame_q && scl_st_q && sda_st_q) begin
            st_d = bwi_pkg::ST_START;
          end
        end
        bwi_pkg::ST_START: begin
          if (min_q) begin
            st_d = bwi_pkg::ST_LOW;
          end
        end
        bwi_pkg::ST_LOW: begin
          if (sw_cmd.gen_stop) begin
            st_d = bwi_pkg::ST_STOP1;
          end else if (sw_cmd.gen_start) begin
            st_d = bwi_pkg::ST_RSTART;
          end else if (!hold) begin
            st_d = bwi_pkg::ST_HIGH;
          end
        end
        bwi_pkg::ST_HIGH: begin
          if (scl_st_q && min_q && !scl_edge) begin
            st_d = bwi_pkg::ST_LOW;
          end
        end
        bwi_pkg::ST_STOP1: begin
          if (scl_st_q && min_q) begin
            st_d = bwi_pkg::ST_STOP2;
          end
        end
        bwi_pkg::ST_STOP2: begin
          if (min_q) begin
            st_d = bwi_pkg::ST_IDLE;
          end
        end
        bwi_pkg::ST_RSTART: begin
          if (scl_st_q && min_q) begin
            st_d = bwi_pkg::ST_START;
          end
        end
        default: begin
          st_d = bwi_pkg::ST_IDLE;
        end
      endcase
    end else begin
      // disabled: let go of the bus
      st_d = bwi_pkg::ST_IDLE;
      in_frame_d = 1'b0;
      xmit_d = 1'b0;
    end
    // timeout carry resets the interface
    if (carry) begin
      flg_d = '0;
      st_d = bwi_pkg::ST_IDLE;
      in_frame_d = 1'b0;
      xmit_d = 1'b0;
      idle_d = 1'b0;
    end
  end

  // interface registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= bwi_pkg::ST_IDLE;
      flg_q <= '0;
      in_frame_q <= 1'b0;
      idle_q <= 1'b0;
      xmit_q <= 1'b0;
      xbit_q <= 1'b1;
      received_bit_q <= `BWI_RECEIVED_BIT_RST;
    end else begin
      st_q <= st_d;
      flg_q <= flg_d;
      in_frame_q <= in_frame_d;
      idle_q <= idle_d;
      xmit_q <= xmit_d;
      xbit_q <= xbit_d;
      received_bit_q <= received_bit_d;
    end
  end

  // output next values
  logic scl_oe_d, sda_oe_d, bus_irq_d, tmo_irq_d; // pin and irq next
  logic [7:0] ctl_d, bit_d; // read values next
  logic [1:0] bus_pri_d, tmo_pri_d; // priorities next

  // pin drive, read values and interrupt requests
  always_comb begin
    scl_oe_d = 1'b0;
    sda_oe_d = 1'b0;
    case (st_q)
      bwi_pkg::ST_START: sda_oe_d = 1'b1;
      bwi_pkg::ST_LOW: begin
        scl_oe_d = 1'b1;
        // sda moves only once scl is seen low, else a false start or stop
        sda_oe_d = scl_st_q ? sda_oe : (xmit_q & ~xbit_q);
      end
      bwi_pkg::ST_HIGH: sda_oe_d = sda_oe; // sda steady while scl high
      bwi_pkg::ST_STOP1: sda_oe_d = 1'b1;
      default: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
      end
    endcase
    if (st_q == bwi_pkg::ST_IDLE && bus_enable && in_frame_q && !idle_q) begin
      // slave: stretch the low period after a ready bit
      scl_oe_d = ~scl_st_q & flg_q.bit_ready_flag;
      sda_oe_d = xmit_q & ~xbit_q;
    end
    if (carry || !bus_enable) begin
      scl_oe_d = 1'b0;
      sda_oe_d = 1'b0;
    end
    ctl_d = {received_bit_q, attention_flag, flg_q, mstr, 1'b0};
    bit_d = {received_bit_q, 7'h00};
    bus_irq_d = global_irq_enable & interrupt_enable_reg_b[`BWI_IEN_BUS_BIT] & attention_flag;
    tmo_irq_d = carry & global_irq_enable & interrupt_enable_reg_b[`BWI_IEN_TMO_BIT];
    bus_pri_d = {priority_reg_high[`BWI_PRI_BUS_BIT], priority_reg_low[`BWI_PRI_BUS_BIT]};
    tmo_pri_d = {priority_reg_high[`BWI_PRI_TMO_BIT], priority_reg_low[`BWI_PRI_TMO_BIT]};
  end

  // output registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      bus_control_reg <= {`BWI_RECEIVED_BIT_RST, 7'h00};
      bus_bit_reg <= {`BWI_RECEIVED_BIT_RST, 7'h00};
      bus_irq <= 1'b0;
      timeout_irq <= 1'b0;
      bus_priority <= 2'h0;
      timeout_priority <= 2'h0;
    end else begin
      scl_o <= 1'b0;
      scl_oe <= scl_oe_d;
      sda_o <= 1'b0;
      sda_oe <= sda_oe_d;
      bus_control_reg <= ctl_d;
      bus_bit_reg <= bit_d;
      bus_irq <= bus_irq_d;
      timeout_irq <= tmo_irq_d;
      bus_priority <= bus_pri_d;
      timeout_priority <= tmo_pri_d;
    end
  end

endmodule : bwi_top
`default_nettype wire

// ---- bwi_top_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module bwi_top_monitor (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic timeout_run_bit,
  input wire bwi_pkg::bwi_cmd_t sw_cmd,
  input wire logic bit_reg_wr,
  input wire logic bit_reg_rd,
  input wire logic global_irq_enable,
  input wire logic [7:0] interrupt_enable_reg_b,
  input wire logic [7:0] priority_reg_high,
  input wire logic [7:0] priority_reg_low,
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic [7:0] bus_control_reg,
  input wire logic [7:0] bus_bit_reg,
  input wire logic bus_irq,
  input wire logic timeout_irq,
  input wire logic [1:0] bus_priority,
  input wire logic [1:0] timeout_priority
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [3:0] quiet_q; // cycles since scl pin moved, saturating
  logic [3:0] quiet_d;
  logic scl_q; // last scl pin level
  // quiet counter restarts on any scl pin change
  always_comb begin
    quiet_d = (scl_i != scl_q) ? 4'h0 : ((quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1);
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      quiet_q <= 4'h0;
      scl_q <= 1'b1;
    end else begin
      quiet_q <= quiet_d;
      scl_q <= scl_i;
    end
  end
  // a clear strobe with no scl edge in flight
  sequence clr_req_s;
    (bit_reg_rd || bit_reg_wr || sw_cmd.clear_bit_ready) && quiet_q == 4'hf;
  endsequence
  sequence tmo_s;
    timeout_irq;
  endsequence
  ready_clear_a: assert property (clr_req_s |-> ##2 !bus_control_reg[5])
    else $error("bit ready not cleared");
  attn_or_a: assert property (bus_control_reg[6] == (|bus_control_reg[5:2]))
    else $error("attention not or of flags");
  bit_fmt_a: assert property (bus_bit_reg == {bus_control_reg[7], 7'h00})
    else $error("bit register format wrong");
  bus_irq_a: assert property (bus_irq == ($past(global_irq_enable) && $past(interrupt_enable_reg_b[0])
    && bus_control_reg[6]))
    else $error("bus irq mismatch");
  tmo_pulse_a: assert property (tmo_s |=> !timeout_irq)
    else $error("timeout irq longer than one cycle");
  tmo_release_a: assert property (tmo_s |-> !scl_oe && !sda_oe ##1 bus_control_reg[5:1] == 5'h00)
    else $error("timeout did not reset interface");
  run_gate_a: assert property (!timeout_run_bit |=> !timeout_irq)
    else $error("timeout while timer stopped");
  irq_gate_a: assert property (tmo_s |-> $past(global_irq_enable) && $past(interrupt_enable_reg_b[7]))
    else $error("timeout irq while disabled");
  prio_map_a: assert property ($past(nrst) |->
    bus_priority == $past({priority_reg_high[0], priority_reg_low[0]})
    && timeout_priority == $past({priority_reg_high[7], priority_reg_low[7]}))
    else $error("priority mapping wrong");
endmodule : bwi_top_monitor
bind bwi_top bwi_top_monitor u_bwi_top_monitor (.mclk(mclk), .nrst(nrst), .timeout_run_bit(timeout_run_bit),
  .sw_cmd(sw_cmd), .bit_reg_wr(bit_reg_wr), .bit_reg_rd(bit_reg_rd), .global_irq_enable(global_irq_enable),
  .interrupt_enable_reg_b(interrupt_enable_reg_b), .priority_reg_high(priority_reg_high),
  .priority_reg_low(priority_reg_low), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .bus_control_reg(bus_control_reg), .bus_bit_reg(bus_bit_reg), .bus_irq(bus_irq), .timeout_irq(timeout_irq),
  .bus_priority(bus_priority), .timeout_priority(timeout_priority));
`default_nettype wire

// ---- bwi_bus_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
module bwi_bus_partner (
  input wire logic scl_line, // wired scl level
  output logic scl_low, // partner pulls scl low
  output logic sda_low // partner pulls sda low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // start: sda falls while scl high, then scl low
  task automatic start();
    #16 sda_low = 1'b1;
    #16 scl_low = 1'b1;
  endtask : start
  // one bit: data set in low phase, high phase waits out any stretch
  task automatic send_bit(input logic b);
    int n = 0;
    #16 sda_low = ~b;
    #16 scl_low = 1'b0;
    while (scl_line !== 1'b1 && n < 5000) begin
      #4 n++;
    end
    #16 scl_low = 1'b1;
    #16;
  endtask : send_bit
  // let go of both lines
  task automatic let_go();
    scl_low = 1'b0;
    sda_low = 1'b0;
  endtask : let_go
endmodule : bwi_bus_partner
`default_nettype wire

// ---- bwi_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module bwi_top_tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0; // active low reset
  logic en = 1'b0;
  logic run = 1'b0;
  logic [1:0] psel = 2'h3; // preload select pair
  bwi_pkg::bwi_cmd_t cmd_v = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ea = 1'b0;
  logic [7:0] ien = 8'h00;
  logic [7:0] ph = 8'h00;
  logic [7:0] pl = 8'h00;
  logic scl_o, scl_oe, sda_o, sda_oe, birq, tirq, p_scl, p_sda;
  logic [7:0] ctl, breg;
  logic [1:0] bpri, tpri;
  wire logic scl_w = ~(scl_oe | p_scl); // pull-up unless someone pulls
  wire logic sda_w = ~(sda_oe | p_sda);
  int error_cnt = 0;
  int comparisons = 0;
  int tmo_cnt = 0; // timeout pulses seen
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (tirq === 1'b1) tmo_cnt++;
  bwi_top u_bwi_top (.mclk(mclk), .nrst(nrst), .bus_enable(en), .timeout_run_bit(run),
    .timing_preload_sel0(psel[0]), .timing_preload_sel1(psel[1]), .sw_cmd(cmd_v), .bit_reg_wr(wr),
    .bit_reg_wdata(1'b1), .bit_reg_rd(rd), .global_irq_enable(ea), .interrupt_enable_reg_b(ien),
    .priority_reg_high(ph), .priority_reg_low(pl), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .bus_control_reg(ctl), .bus_bit_reg(breg),
    .bus_irq(birq), .timeout_irq(tirq), .bus_priority(bpri), .timeout_priority(tpri));
  bwi_bus_partner u_bwi_bus_partner (.scl_line(scl_w), .scl_low(p_scl), .sda_low(p_sda));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // wait edges, then let outputs settle
  task automatic clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : clk
  // one-cycle strobes
  task automatic strobe(input bwi_pkg::bwi_cmd_t c, input logic r, input logic w);
    @(posedge mclk);
    cmd_v <= c;
    rd <= r;
    wr <= w;
    @(posedge mclk);
    cmd_v <= '0;
    rd <= 1'b0;
    wr <= 1'b0;
    clk(4);
  endtask : strobe
  // reset values, no timer run outside a frame
  task automatic t_reset();
    chk("control", 8'h80, ctl);
    chk("bit reg", 8'h80, breg);
    run <= 1'b1;
    en <= 1'b1;
    clk(1100);
    chk("timeouts", 8'h00, tmo_cnt[7:0]);
  endtask : t_reset
  // slave receives bits, each cleared another way
  task automatic t_bits();
    logic [2:0] b = 3'b101;
    ea <= 1'b1;
    ien <= 8'h81;
    u_bwi_bus_partner.start();
    clk(8);
    chk("start irq", 8'h03, {6'h00, ctl[3], birq});
    strobe(8'h08, 1'b0, 1'b0);
    chk("attention", 8'h00, {7'h00, ctl[6]});
    for (int i = 0; i < 3; i++) begin
      u_bwi_bus_partner.send_bit(b[i]);
      clk(8);
      chk("received_bit ready", {6'h00, b[i], 1'b1}, {6'h00, ctl[7], ctl[5]});
      chk("bit reg", {b[i], 7'h00}, breg);
      chk("stretch irq", 8'h03, {6'h00, scl_oe, birq});
      strobe((i == 1) ? 8'h20 : 8'h00, i == 0, i == 2);
      chk("cleared", 8'h00, {6'h00, ctl[5], scl_oe});
    end
  endtask : t_bits
  // stuck low clock: held while stopped, carry once running
  task automatic t_timeout();
    int n = 0;
    // timer frozen at its preload while stopped, so the span counts from the run bit
    run <= 1'b0;
    u_bwi_bus_partner.send_bit(1'b0);
    clk(8);
    u_bwi_bus_partner.let_go();
    clk(1200);
    chk("stopped", 8'h01, {tmo_cnt[6:0], scl_oe});
    run <= 1'b1;
    while (tirq !== 1'b1 && n < 1100) begin
      clk(1);
      n++;
    end
    chk("carry span", 8'h01, {7'h00, n >= 1021 && n <= 1024});
    clk(1);
    chk("after carry", 8'h00, {3'h0, ctl[5:2], scl_oe});
    chk("timeouts", 8'h01, tmo_cnt[7:0]);
  endtask : t_timeout
  // priority bits of both registers
  task automatic t_prio();
    for (int i = 0; i < 4; i++) begin
      ph <= {i[1], 6'h00, i[0]};
      pl <= {i[0], 6'h00, i[1]};
      clk(3);
      chk("priority", {4'h0, i[0], i[1], i[1], i[0]}, {4'h0, bpri, tpri});
    end
  endtask : t_prio
  // master: start, held by a flag, one bit, stop
  task automatic t_master();
    strobe(8'h3c, 1'b0, 1'b0);
    strobe(8'h02, 1'b0, 1'b0);
    clk(40);
    chk("master start", 8'h07, {5'h00, ctl[3], ctl[1], scl_oe});
    strobe(8'h08, 1'b0, 1'b0);
    clk(40);
    chk("master bit", 8'h0f, {4'h0, ctl[7], ctl[5], ctl[1], scl_oe});
    strobe(8'h01, 1'b0, 1'b0);
    clk(40);
    chk("master stop", 8'h08, {4'h0, ctl[2], ctl[1], scl_oe, sda_oe});
  endtask : t_master
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    clk(12);
    nrst <= 1'b1;
    clk(2);
    t_reset();
    t_bits();
    t_timeout();
    t_prio();
    t_master();
    give_verdict();
  end
endmodule : bwi_top_tb_top
`default_nettype wire
